/* File: design/ring_cmd_pkg.sv */
// Shared constants and carrier types for the circular-memory command engine.
// Assumes a single 125 MHz core clock; the SPI pins arrive unsynchronised.
`default_nettype none
package ring_cmd_pkg;
	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] OP_CAPTURE = 8'h41;
	localparam logic [7:0] OP_ERASE_ONE = 8'h42;
	localparam logic [7:0] OP_ERASE_ALL = 8'h43;
	localparam logic [7:0] OP_SKIP = 8'h48;
	localparam logic [7:0] OP_VERIFY = 8'h49;
	localparam logic [7:0] OP_FETCH_PTR = 8'h06;
	localparam logic [7:0] OP_HALT = 8'h02;
	localparam logic [7:0] OP_RESET = 8'h03;
	localparam logic [7:0] OP_ACK = 8'h04;
	localparam logic [7:0] OP_POLL = 8'h05;
	localparam logic [7:0] OP_SLEEP = 8'h07;
	// ****************************************
	// Memory rows
	// ****************************************
	localparam int ROW_W = 11;
	localparam logic [10:0] SE_LAST_ROW = 11'h00f;
	localparam logic [10:0] FIRST_MSG_ROW = 11'h010;
	localparam logic [10:0] ROW_LIMIT_RST = 11'h7ff;
	localparam int MSG_MAX_DEF = 8;
	// ****************************************
	// Status bit positions
	// ****************************************
	localparam int SR0_FAULT = 0;
	localparam int SR0_FULL = 1;
	localparam int SR0_PWR = 2;
	localparam int SR0_MEND = 3;
	localparam int SR0_IRQ = 4;
	localparam int SR1_READY = 0;
	localparam int SR1_ERASE = 1;
	localparam int SR1_PLAY = 2;
	localparam int SR1_CAPTURE = 3;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int ROW_TIME_NS = 128;
	localparam int ROW_CYCLES = (ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ****************************************
	// Register bus map
	// ****************************************
	localparam int AXI_ADDR_W = 5;
	localparam logic [4:0] REG_STATUS = 5'h00;
	localparam logic [4:0] REG_PTRS = 5'h04;
	localparam logic [4:0] REG_LIMIT = 5'h08;
	localparam logic [4:0] REG_TABLE = 5'h0c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0]
	{
		ST_IDLE = 4'b0001,
		ST_CAPTURE = 4'b0010,
		ST_ERASE_ONE = 4'b0100,
		ST_ERASE_ALL = 4'b1000
	} eng_state_t;
	typedef struct packed {
		logic [7:0] data;
		logic valid;
		logic [1:0] idx;
		logic frame_end;
	} spi_byte_t;
	typedef struct packed {
		logic [7:0] sr1;
		logic [7:0] sr0;
	} status_t;
endpackage
`default_nettype wire

/* File: design/spi_byte_port.sv */
// SPI target byte framer, mode 3, least significant bit first.
// Assumes pins are asynchronous; all three pass two flip-flops first.
`default_nettype none
module spi_byte_port
	import ring_cmd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// Pins
	input wire logic spi_sclk,
	input wire logic spi_ss_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe_n,
	// Byte side
	input wire logic [7:0] tx_byte,
	output logic [1:0] tx_idx,
	output ring_cmd_pkg::spi_byte_t rx
);
	import ring_cmd_pkg::*;
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic psclk;
		logic pss;
		logic [7:0] rx_sh;
		logic [7:0] tx_sh;
		logic [2:0] bitc;
		logic [1:0] idx;
		logic miso;
		logic oe_n;
		spi_byte_t out;
	} port_t;
	port_t s, n;
	logic sclk_s, ss_s, mosi_s;

	always_comb
	begin
		n = s;
		sclk_s = s.s2[2];
		ss_s = s.s2[1];
		mosi_s = s.s2[0];
		n.s1 = {spi_sclk, spi_ss_n, spi_mosi};
		n.s2 = s.s1;
		n.psclk = sclk_s;
		n.pss = ss_s;
		n.out.valid = 1'b0;
		n.out.frame_end = 1'b0;
		if (ss_s)
		begin
			n.out.frame_end = !s.pss;
			n.oe_n = 1'b1;
			n.bitc = 3'h0;
			n.idx = 2'h0;
		end
		else if (s.pss)
		begin
			n.tx_sh = tx_byte;
			n.miso = tx_byte[0];
			n.oe_n = 1'b0;
			n.bitc = 3'h0;
			n.idx = 2'h0;
		end
		else
		begin
			if (sclk_s && !s.psclk)
			begin
				n.rx_sh = {mosi_s, s.rx_sh[7:1]};
				n.bitc = s.bitc + 3'h1;
				if (s.bitc == 3'h7)
				begin
					n.out.data = {mosi_s, s.rx_sh[7:1]};
					n.out.valid = 1'b1;
					n.out.idx = s.idx;
					n.idx = (s.idx == 2'h3) ? 2'h3 : s.idx + 2'h1;
				end
			end
			if (!sclk_s && s.psclk)
			begin
				// Next byte is fetched only at a byte boundary
				if (s.bitc == 3'h0)
				begin
					n.tx_sh = tx_byte;
					n.miso = tx_byte[0];
				end
				else
				begin
					n.tx_sh = {1'b0, s.tx_sh[7:1]};
					n.miso = s.tx_sh[1];
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s <= '0;
			s.s1 <= 3'h7;
			s.s2 <= 3'h7;
			s.psclk <= 1'b1;
			s.pss <= 1'b1;
			s.oe_n <= 1'b1;
		end
		else if (ce)
		begin
			s <= n;
		end
	end

	assign spi_miso = s.miso;
	assign spi_miso_oe_n = s.oe_n;
	assign tx_idx = s.idx;
	assign rx = s.out;
endmodule
`default_nettype wire

/* File: design/axil_regs.sv */
// AXI4-Lite slave holding the row limit and mirroring engine state.
// Assumes the master sits on ref_clk; no synchronisers needed.
`default_nettype none
module axil_regs
	import ring_cmd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// AXI4-Lite
	input wire logic [ring_cmd_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ring_cmd_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Engine side
	input wire ring_cmd_pkg::status_t status,
	input wire logic [31:0] ptr_word,
	input wire logic [31:0] table_word,
	output logic [10:0] row_limit
);
	import ring_cmd_pkg::*;
	typedef struct packed {
		logic aw_have;
		logic [AXI_ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic arready;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [10:0] limit;
	} bus_t;
	bus_t s, n;

	function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
		mapped = (a == REG_STATUS) || (a == REG_PTRS) || (a == REG_LIMIT) || (a == REG_TABLE);
	endfunction

	always_comb
	begin
		n = s;
		if (awvalid && s.awready)
		begin
			n.aw_have = 1'b1;
			n.aw_addr = awaddr;
		end
		if (wvalid && s.wready)
		begin
			n.w_have = 1'b1;
			n.w_data = wdata;
			n.w_strb = wstrb;
		end
		if (s.bvalid && bready)
			n.bvalid = 1'b0;
		if (n.aw_have && n.w_have && !n.bvalid)
		begin
			if (n.aw_addr == REG_LIMIT)
			begin
				if (n.w_strb[0])
					n.limit[7:0] = n.w_data[7:0];
				if (n.w_strb[1])
					n.limit[10:8] = n.w_data[10:8];
			end
			// Read-only words ignore writes; holes answer with an error
			n.bresp = mapped(n.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			n.bvalid = 1'b1;
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
		end
		n.awready = !n.aw_have && !n.bvalid;
		n.wready = !n.w_have && !n.bvalid;
		if (s.rvalid && rready)
			n.rvalid = 1'b0;
		if (arvalid && s.arready)
		begin
			n.rvalid = 1'b1;
			n.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			case (araddr)
				REG_STATUS: n.rdata = {16'h0, status};
				REG_PTRS: n.rdata = ptr_word;
				REG_LIMIT: n.rdata = {21'h0, s.limit};
				REG_TABLE: n.rdata = table_word;
				default: n.rdata = 32'h0;
			endcase
		end
		n.arready = !n.rvalid;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s <= '0;
			s.limit <= ROW_LIMIT_RST;
		end
		else if (ce)
		begin
			s <= n;
		end
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bresp = s.bresp;
	assign bvalid = s.bvalid;
	assign arready = s.arready;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign rvalid = s.rvalid;
	assign row_limit = s.limit;
endmodule
`default_nettype wire

/* File: design/ring_cmd_engine.sv */
// Circular-memory command engine: SPI opcode decode, pointer and message table.
// Assumes an SPI host on the pins and an AXI4-Lite master on ref_clk.
//
// The register offsets and the AXI4-Lite register port were decided locally.
`default_nettype none
// Function
// - 0x41 starts capture at capture pointer; halt or full array ends it
// - During capture only halt, reset, ack, poll, sleep; others flag fault
// - Ready and capture-active status bits held low throughout capture
// - 0x42 erases current message row by row up to its end mark
// - Single erase only for first or last message, else fault, nothing erased
// - During single erase halt and other commands flag fault
// - Ready and erase-active bits low during single erase
// - 0x43 erases all messages but never sound-effect rows 0x000-0x00F
// - Global erase holds ready/erase bits low, refuses other commands with fault
// - 0x48 moves output pointer to next message start
// - Skip runs only from idle, never interrupting an operation
// - 0x49 checks ring layout, fault on failure
// - Passing check points output at last message, capture at first free row
// - 0x06 returns status, pointer bits 7:0, then bits 10:8
// - Every ring command first verifies layout; mismatch flags fault, skips
// - Acknowledge clears interrupt and message end flags, releases pin
module ring_cmd_engine
	import ring_cmd_pkg::*;
#(
	parameter int MSG_MAX = ring_cmd_pkg::MSG_MAX_DEF
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// SPI pins
	input wire logic spi_sclk,
	input wire logic spi_ss_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe_n,
	// Interrupt pin, active low
	output logic irq_n,
	// AXI4-Lite
	input wire logic [ring_cmd_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ring_cmd_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	import ring_cmd_pkg::*;
	localparam int IDX_W = $clog2(MSG_MAX);
	localparam int CNT_W = $clog2(MSG_MAX + 1);
	localparam int TMR_W = $clog2(ROW_CYCLES + 1);
	localparam logic [TMR_W-1:0] TICK_LAST = TMR_W'(ROW_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(MSG_MAX);
	typedef logic [MSG_MAX-1:0][10:0] starts_t;
	typedef struct packed {
		eng_state_t st;
		logic [7:0] op;
		logic op_bad;
		logic [1:0] nb;
		logic [10:0] cap_ptr;
		logic [10:0] out_ptr;
		logic [IDX_W-1:0] cur;
		logic [CNT_W-1:0] cnt;
		starts_t starts;
		logic [10:0] end_row;
		logic [10:0] row;
		logic [TMR_W-1:0] tmr;
		logic fault;
		logic full;
		logic mend;
		logic irq;
		logic irq_n;
	} eng_t;
	eng_t s, n;
	spi_byte_t rx;
	logic [1:0] tx_idx;
	logic [7:0] tx_byte;
	logic [10:0] row_limit;
	status_t status;
	logic go, tick, ok, busy_ok, idle_ok, last_msg;
	logic [10:0] msg_end;

	// ****************************************
	// Layout check
	// ****************************************
	function automatic logic ring_ok(input starts_t st, input logic [CNT_W-1:0] c,
		input logic [10:0] e);
		ring_ok = 1'b1;
		if (c != '0 && st[0] < FIRST_MSG_ROW)
			ring_ok = 1'b0;
		for (int i = 0; i < MSG_MAX; i++)
		begin
			if (i + 1 < int'(c) && st[i] >= st[(i + 1) % MSG_MAX])
				ring_ok = 1'b0;
			if (i + 1 == int'(c) && st[i] > e)
				ring_ok = 1'b0;
		end
	endfunction

	function automatic logic ring_cmd(input logic [7:0] op);
		ring_cmd = (op == OP_CAPTURE) || (op == OP_ERASE_ONE) || (op == OP_ERASE_ALL) ||
			(op == OP_SKIP) || (op == OP_VERIFY);
	endfunction

	// ****************************************
	// Status and reply bytes
	// ****************************************
	always_comb
	begin
		status.sr0 = 8'h0;
		status.sr0[SR0_FAULT] = s.fault;
		status.sr0[SR0_FULL] = s.full;
		status.sr0[SR0_PWR] = 1'b1;
		status.sr0[SR0_MEND] = s.mend;
		status.sr0[SR0_IRQ] = s.irq;
		status.sr1 = 8'h0;
		status.sr1[SR1_READY] = (s.st == ST_IDLE);
		status.sr1[SR1_ERASE] = !(s.st == ST_ERASE_ONE || s.st == ST_ERASE_ALL);
		status.sr1[SR1_PLAY] = 1'b1;
		status.sr1[SR1_CAPTURE] = (s.st != ST_CAPTURE);
		case (tx_idx)
			2'h2: tx_byte = (s.op == OP_FETCH_PTR) ? s.out_ptr[7:0] : status.sr0;
			2'h3: tx_byte = (s.op == OP_FETCH_PTR) ? {5'h0, s.out_ptr[10:8]} : 8'h0;
			default: tx_byte = status.sr0;
		endcase
	end

	// ****************************************
	// Command sequencer
	// ****************************************
	always_comb
	begin
		n = s;
		go = rx.frame_end && s.nb == 2'h2 && !s.op_bad;
		tick = (s.tmr == TICK_LAST);
		ok = ring_ok(s.starts, s.cnt, s.end_row);
		last_msg = (CNT_W'(s.cur) + 1'b1 == s.cnt);
		msg_end = last_msg ? s.end_row : s.starts[s.cur + 1'b1];
		busy_ok = (s.op == OP_RESET) || (s.op == OP_ACK) || (s.op == OP_POLL) ||
			(s.op == OP_SLEEP);
		idle_ok = busy_ok || (s.op == OP_HALT);
		if (rx.valid)
		begin
			if (rx.idx == 2'h0)
			begin
				n.op = rx.data;
				n.op_bad = 1'b0;
				n.nb = 2'h1;
			end
			else if (rx.idx == 2'h1)
			begin
				n.op_bad = (rx.data != 8'h0);
				n.nb = 2'h2;
			end
		end
		if (rx.frame_end)
			n.nb = 2'h0;
		if (go && s.op == OP_ACK)
		begin
			n.irq = 1'b0;
			n.mend = 1'b0;
		end
		n.tmr = (s.st == ST_IDLE || tick) ? '0 : s.tmr + 1'b1;
		case (s.st)
			ST_IDLE:
			begin
				// Nothing runs here while busy, so skip never cuts an operation short
				if (go && ring_cmd(s.op))
				begin
					if (!ok)
						n.fault = 1'b1;
					else
					begin
						n.fault = 1'b0;
						case (s.op)
							OP_CAPTURE:
							begin
								if (s.cnt == CNT_FULL || s.cap_ptr >= row_limit)
									n.fault = 1'b1;
								else
								begin
									n.st = ST_CAPTURE;
									n.starts[s.cnt[IDX_W-1:0]] = s.cap_ptr;
									n.row = s.cap_ptr;
									n.full = 1'b0;
								end
							end
							OP_ERASE_ONE:
							begin
								if (s.cnt == '0 || (s.cur != '0 && !last_msg))
									n.fault = 1'b1;
								else
								begin
									n.st = ST_ERASE_ONE;
									n.row = s.starts[s.cur];
								end
							end
							OP_ERASE_ALL:
							begin
								n.st = ST_ERASE_ALL;
								n.row = FIRST_MSG_ROW;
							end
							OP_SKIP:
							begin
								n.cur = last_msg ? '0 : s.cur + 1'b1;
								n.out_ptr = (s.cnt == '0) ? FIRST_MSG_ROW : s.starts[n.cur];
								n.irq = 1'b1;
							end
							OP_VERIFY:
							begin
								n.cur = (s.cnt == '0) ? '0 : IDX_W'(s.cnt - 1'b1);
								n.out_ptr = (s.cnt == '0) ? FIRST_MSG_ROW : s.starts[n.cur];
								n.cap_ptr = (s.cnt == '0) ? FIRST_MSG_ROW : s.end_row;
								n.irq = 1'b1;
							end
							default: n.fault = s.fault;
						endcase
					end
				end
			end
			ST_CAPTURE:
			begin
				if (go && !idle_ok)
					n.fault = 1'b1;
				if ((go && s.op == OP_HALT) || (tick && s.row + 11'h1 >= row_limit))
				begin
					// A row in flight is dropped on halt; the message ends at it
					n.full = !(go && s.op == OP_HALT);
					n.end_row = (go && s.op == OP_HALT) ? s.row : s.row + 11'h1;
					n.cap_ptr = n.end_row;
					n.cur = s.cnt[IDX_W-1:0];
					n.out_ptr = s.starts[s.cnt[IDX_W-1:0]];
					n.cnt = s.cnt + 1'b1;
					n.irq = 1'b1;
					n.st = ST_IDLE;
				end
				else if (tick)
				begin
					n.row = s.row + 11'h1;
					n.cap_ptr = s.row + 11'h1;
				end
			end
			ST_ERASE_ONE:
			begin
				if (go && !busy_ok)
					n.fault = 1'b1;
				if (tick)
				begin
					n.row = s.row + 11'h1;
					if (s.row + 11'h1 >= msg_end)
					begin
						n.cnt = s.cnt - 1'b1;
						if (last_msg)
						begin
							n.end_row = s.starts[s.cur];
							n.cur = (s.cur == '0) ? '0 : s.cur - 1'b1;
						end
						else
						begin
							for (int i = 0; i < MSG_MAX - 1; i++)
								n.starts[i] = s.starts[i + 1];
							n.cur = '0;
						end
						n.cap_ptr = n.end_row;
						n.out_ptr = (n.cnt == '0) ? FIRST_MSG_ROW : n.starts[n.cur];
						n.mend = 1'b1;
						n.irq = 1'b1;
						n.st = ST_IDLE;
					end
				end
			end
			ST_ERASE_ALL:
			begin
				if (go && !busy_ok)
					n.fault = 1'b1;
				if (tick)
				begin
					n.row = s.row + 11'h1;
					if (s.row + 11'h1 >= s.end_row)
					begin
						n.cnt = '0;
						n.cur = '0;
						n.end_row = FIRST_MSG_ROW;
						n.cap_ptr = FIRST_MSG_ROW;
						n.out_ptr = FIRST_MSG_ROW;
						n.irq = 1'b1;
						n.st = ST_IDLE;
					end
				end
			end
			default: n.st = ST_IDLE;
		endcase
		n.irq_n = !n.irq;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s <= '0;
			s.st <= ST_IDLE;
			s.irq_n <= 1'b1;
			s.cap_ptr <= FIRST_MSG_ROW;
			s.out_ptr <= FIRST_MSG_ROW;
			s.end_row <= FIRST_MSG_ROW;
		end
		else if (ce)
		begin
			s <= n;
		end
	end

	assign irq_n = s.irq_n;

	// ****************************************
	// Sub-blocks
	// ****************************************
	spi_byte_port u_spi (
		.ref_clk(ref_clk), .nrst(nrst), .ce(ce),
		.spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
		.tx_byte(tx_byte), .tx_idx(tx_idx), .rx(rx)
	);

	axil_regs u_regs (
		.ref_clk(ref_clk), .nrst(nrst), .ce(ce),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.status(status),
		.ptr_word({5'h0, s.out_ptr, 5'h0, s.cap_ptr}),
		.table_word({16'h0, 4'(s.st), 4'(s.cur), 8'(s.cnt)}),
		.row_limit(row_limit)
	);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence seq_go_idle(logic [7:0] code);
		ce && go && s.st == ST_IDLE && s.op == code;
	endsequence

	sequence seq_done;
		ce && s.st != ST_IDLE ##1 s.st == ST_IDLE;
	endsequence

	AST_CAPTURE_BITS: assert property (s.st == ST_CAPTURE |-> !status.sr1[SR1_READY] && !status.sr1[SR1_CAPTURE])
		else $error("capture status bits not low");
	AST_ERASE_BITS: assert property ((s.st == ST_ERASE_ONE || s.st == ST_ERASE_ALL)
		|-> !status.sr1[SR1_READY] && !status.sr1[SR1_ERASE])
		else $error("erase status bits not low");
	AST_CAPTURE_START: assert property (seq_go_idle(OP_CAPTURE) ##0 (ok && s.cnt != CNT_FULL &&
		s.cap_ptr < row_limit) |=> s.st == ST_CAPTURE && s.row == $past(s.cap_ptr))
		else $error("capture did not start at capture pointer");
	AST_BUSY_FAULT: assert property (ce && go && s.st == ST_CAPTURE && !idle_ok |=> s.fault)
		else $error("refused command during capture left no fault");
	AST_ERASE_REFUSE: assert property (ce && go && s.st != ST_IDLE && s.st != ST_CAPTURE &&
		s.op == OP_HALT |=> s.fault && s.st != ST_IDLE)
		else $error("halt during erase not refused");
	AST_ERASE_MIDDLE: assert property (seq_go_idle(OP_ERASE_ONE) ##0 (ok && s.cnt > 2 &&
		s.cur != '0 && !last_msg) |=> s.fault && s.st == ST_IDLE && s.cnt == $past(s.cnt))
		else $error("middle message erase not refused");
	AST_SE_ROWS_KEPT: assert property (s.st == ST_ERASE_ALL |-> s.row > SE_LAST_ROW)
		else $error("global erase reached sound effect rows");
	AST_SKIP_PTR: assert property (seq_go_idle(OP_SKIP) ##0 (ok && s.cnt > 1 && s.cur == '0)
		|=> s.out_ptr == $past(s.starts[1]) ##0 !irq_n[*2])
		else $error("skip did not reach next message start");
	AST_BAD_LAYOUT: assert property (ce && go && s.st == ST_IDLE && ring_cmd(s.op) && !ok
		|=> s.fault && s.st == ST_IDLE)
		else $error("bad layout did not block command");
	AST_VERIFY_PTRS: assert property (seq_go_idle(OP_VERIFY) ##0 (ok && s.cnt != '0)
		|=> s.cap_ptr == $past(s.end_row) && s.cur == $past(s.cnt[IDX_W-1:0]) - 1'b1)
		else $error("layout check left pointers wrong");
	AST_DONE_IRQ: assert property (seq_done |-> s.irq ##1 !irq_n)
		else $error("completion raised no interrupt");
	AST_ACK_CLEARS: assert property (ce && go && s.op == OP_ACK && s.st == ST_IDLE
		|=> !s.irq && !s.mend ##1 irq_n)
		else $error("acknowledge did not release interrupt");
endmodule
`default_nettype wire

/* File: bench/spi_host_model.sv */
// SPI host model: mode 3 frames, least significant bit first.
// Assumes the engine samples the pins through its own synchronisers.
`default_nettype none
module spi_host_model
(
	// Pins
	output logic spi_sclk = 1'h1,
	output logic spi_ss_n = 1'h1,
	output logic spi_mosi = 1'h0,
	input wire logic spi_miso
);
	timeunit 1ns;
	timeprecision 1ps;
	// Clock stands high between frames; 40 ns half period
	task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
		rx = 32'h0;
		#3;
		spi_ss_n = 1'h0;
		#40;
		for (int i = 0; i < nbits; i++)
		begin
			spi_sclk = 1'h0;
			spi_mosi = tx[i];
			#40;
			spi_sclk = 1'h1;
			rx[i] = spi_miso;
			#40;
		end
		spi_ss_n = 1'h1;
		// Released line shows the inverse, never a stale bit
		spi_mosi = ~spi_mosi;
		#80;
	endtask
endmodule
`default_nettype wire

/* File: bench/circular_memory_command_engine_tb_top.sv */
// Bench top: engine driven by the SPI host model and an AXI4-Lite master.
// Assumes the engine's default message table size.
`default_nettype none
module circular_memory_command_engine_tb_top;
	import ring_cmd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'h0;
	logic nrst = 1'h0;
	logic spi_sclk, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe_n, irq_n;
	logic [4:0] awaddr = 5'h0, araddr = 5'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d, rx, lim;
	logic ce = 1'h1;
	int msgs[$];
	int mismatches = 0, compares = 0;
	spi_host_model u_host (.spi_sclk, .spi_ss_n, .spi_mosi, .spi_miso);
	ring_cmd_engine u_dut (.ref_clk, .nrst, .ce, .spi_sclk, .spi_ss_n, .spi_mosi,
		.spi_miso, .spi_miso_oe_n, .irq_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready);
	initial
		forever #4 ref_clk = ~ref_clk;
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task automatic close_out;
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		// Handshakes judged on settled values, never in the edge's own time step
		forever
		begin
			@(negedge ref_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge ref_clk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			if (tb) break;
		end
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [4:0] a);
		logic ta, tr;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		forever
		begin
			@(negedge ref_clk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge ref_clk);
			if (ta) arvalid <= 1'h0;
			if (tr) break;
		end
		rready <= 1'h0;
	endtask
	task automatic cmd(input logic [7:0] op);
		u_host.frame({24'h0, op}, 16, rx);
		repeat (8) @(posedge ref_clk);
		chk({31'h0, spi_miso_oe_n}, 32'h1);
	endtask
	task automatic flt(input logic [31:0] e);
		rd(REG_STATUS);
		chk({31'h0, d[SR0_FAULT]}, e);
	endtask
	task automatic ptr(input logic [31:0] e);
		u_host.frame(32'h6, 32, rx);
		chk({16'h0, rx[31:16]}, e);
		chk({31'h0, rx[SR0_PWR]}, 32'h1);
		chk({31'h0, irq_n}, 32'h1);
	endtask
	task automatic irq_wait;
		for (int i = 0; i < 40000 && irq_n !== 1'h0; i++)
			@(posedge ref_clk);
		chk({31'h0, irq_n}, 32'h0);
		cmd(OP_ACK);
		chk({31'h0, irq_n}, 32'h1);
		rd(REG_STATUS);
		chk({30'h0, d[4:3]}, 32'h0);
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial
	begin
		d = $urandom(32'h2f788041);
		repeat (5) @(posedge ref_clk);
		nrst <= 1'h1;
		rd(REG_PTRS);
		chk(d, 32'h0010_0010);
		rd(5'h10);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		lim = 32'h400 | ($urandom % 32'h400);
		wr(REG_LIMIT, lim);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		rd(REG_LIMIT);
		chk(d, lim);
		for (int m = 0; m < 3; m++)
		begin
			rd(REG_PTRS);
			msgs.push_back(int'(d[10:0]));
			cmd(OP_CAPTURE);
			rd(REG_STATUS);
			chk({28'h0, d[11:8]}, 32'h6);
			cmd(OP_SKIP);
			flt(32'h1);
			repeat (300 + $urandom % 100) @(posedge ref_clk);
			cmd(OP_HALT);
			irq_wait;
		end
		// Idle and powered before the layout check
		cmd(OP_VERIFY);
		irq_wait;
		flt(32'h0);
		ptr(msgs[2]);
		// Halt first, as a host leaving playback would
		cmd(OP_HALT);
		cmd(OP_SKIP);
		irq_wait;
		ptr(msgs[0]);
		cmd(OP_SKIP);
		irq_wait;
		ptr(msgs[1]);
		cmd(OP_ERASE_ONE);
		flt(32'h1);
		rd(REG_TABLE);
		chk({24'h0, d[7:0]}, msgs.size());
		cmd(OP_SKIP);
		irq_wait;
		ptr(msgs[2]);
		cmd(OP_ERASE_ONE);
		rd(REG_STATUS);
		chk({28'h0, d[11:8]}, 32'hc);
		cmd(OP_HALT);
		flt(32'h1);
		irq_wait;
		void'(msgs.pop_back());
		rd(REG_TABLE);
		chk({24'h0, d[7:0]}, msgs.size());
		cmd(OP_ERASE_ALL);
		rd(REG_STATUS);
		chk({28'h0, d[11:8]}, 32'hc);
		cmd(OP_SKIP);
		flt(32'h1);
		irq_wait;
		rd(REG_TABLE);
		chk({24'h0, d[7:0]}, 32'h0);
		// Short limit so the array fills; a frame sent while frozen is lost
		wr(REG_LIMIT, 32'h14);
		cmd(OP_CAPTURE);
		repeat (100) @(posedge ref_clk);
		ce <= 1'h0;
		cmd(OP_ACK);
		chk({31'h0, irq_n}, 32'h0);
		ce <= 1'h1;
		irq_wait;
		rd(REG_STATUS);
		chk({31'h0, d[SR0_FULL]}, 32'h1);
		close_out;
	end
	initial
	begin
		#600000;
		mismatches++;
		close_out;
	end
endmodule
`default_nettype wire
